// ---- logic/atp_consts.vh ----
// Constants for the dual-slope timer with crystal clocking and prescaler.
// Assumes inclusion by the timer modules and the bench; holds definitions alone.
//
// Behaviour
// - Mode field one runs the counter dual-slope.
// - Eight-bit resolution; MAX held one timer cycle.
// - Setting 2 clears up, sets down; 3 inverse.
// - Overflow flag set on every arrival at BOTTOM.
// - Compare BOTTOM constant low, MAX constant high.
// - Output may toggle without match for symmetry.
// - At MAX output equals the up-count result unless compare is MAX.
// - Async writes pass through holding register, two edges.
// - Pending counter/compare write disables compare function.
// - Wake interrupt logic rearms after one oscillator cycle.
// - Wake starts on the following timer cycle.
// - Async counter reads via synchronised shadow register.
// - Async flags take three CPU plus one timer cycle.
// - Async waveform output changes on timer clock.
// - Async select clocks from crystal, detaches pins.
// - Prescaler: undivided, /8../1024 taps, or stopped.
// - Prescaler reset bit restarts prescaler phase.
// - Oscillator stops in deep sleep; registers lost.
// - Three-bit clock select: zero stops, ascending taps.
`ifndef ATP_CONSTS_VH
`define ATP_CONSTS_VH

`define ATP_OFF_CONTROL    5'h00
`define ATP_OFF_COUNTER    5'h04
`define ATP_OFF_COMPARE    5'h08
`define ATP_OFF_ASYNC      5'h0c
`define ATP_OFF_FLAGS      5'h10
`define ATP_OFF_IRQ_EN     5'h14
`define ATP_OFF_SPECIAL    5'h18

`define ATP_CTL_FORCE_BIT  7
`define ATP_CTL_WGM0_BIT   6
`define ATP_CTL_WGM1_BIT   3
`define ATP_CTL_COM_HI     5
`define ATP_CTL_COM_LO     4
`define ATP_CTL_CS_HI      2
`define ATP_CTL_CS_LO      0

`define ATP_ASY_CTL_BUSY   0
`define ATP_ASY_CMP_BUSY   1
`define ATP_ASY_CNT_BUSY   2
`define ATP_ASY_SEL_BIT    3

`define ATP_FLG_OVF_BIT    0
`define ATP_FLG_CMP_BIT    1
`define ATP_SFR_PSR_BIT    0

`define ATP_RESET_BYTE     8'h00
`define ATP_BOTTOM         8'h00
`define ATP_MAX            8'hff
`define ATP_MODE_PHASE     2'h1

`define ATP_COM_OFF        2'h0
`define ATP_COM_TOGGLE     2'h1
`define ATP_COM_CLEAR      2'h2
`define ATP_COM_SET        2'h3

`define ATP_HOLD_EDGES     2'h2
`define ATP_FLAG_SYNC_CPU  3

`define ATP_CS_STOP        3'h0
`define ATP_CS_DIRECT      3'h1
`define ATP_MASK_DIV8      10'h007
`define ATP_MASK_DIV32     10'h01f
`define ATP_MASK_DIV64     10'h03f
`define ATP_MASK_DIV128    10'h07f
`define ATP_MASK_DIV256    10'h0ff
`define ATP_MASK_DIV1024   10'h3ff

`endif

// ---- logic/atp_prescaler.v ----
// Prescaler producing the timer clock enable from the source tick.
// Assumes srcTick is a one-cycle enable in the clk domain.
`timescale 1ns/1ps
`include "atp_consts.vh"

module atp_prescaler (
	// Clock and control
	input  wire       clk,
	input  wire       reset,
	input  wire       ce,
	input  wire       clear,
	// Source and selection
	input  wire       srcTick,
	input  wire [2:0] clockSelect,
	// Timer clock enable
	output wire       timerTick
);

	reg  [9:0] div_reg;
	wire [9:0] mask;

	function [9:0] tapMask;
		input [2:0] sel;
		begin
			case (sel)
			3'h2:    tapMask = `ATP_MASK_DIV8;
			3'h3:    tapMask = `ATP_MASK_DIV32;
			3'h4:    tapMask = `ATP_MASK_DIV64;
			3'h5:    tapMask = `ATP_MASK_DIV128;
			3'h6:    tapMask = `ATP_MASK_DIV256;
			3'h7:    tapMask = `ATP_MASK_DIV1024;
			default: tapMask = 10'h000;
			endcase
		end
	endfunction

	assign mask = tapMask(clockSelect);
	// A tap fires on the source tick that completes its count.
	assign timerTick = (clockSelect != `ATP_CS_STOP) & srcTick &
		((div_reg & mask) == mask);

	always @(posedge clk) begin
		if (reset) begin
			div_reg <= 10'h000;
		end else if (ce) begin
			if (clear) begin
				div_reg <= 10'h000;
			end else if (srcTick) begin
				div_reg <= div_reg + 10'h001;
			end
		end
	end

endmodule

// ---- logic/atp_async_hold.v ----
// Holding register for one timer register written in crystal mode.
// Assumes oscRise is a one-cycle pulse per rising oscillator edge.
`timescale 1ns/1ps
`include "atp_consts.vh"

module atp_async_hold (
	// Clock and control
	input  wire       clk,
	input  wire       reset,
	input  wire       ce,
	// Write side
	input  wire       load,
	input  wire [7:0] dataIn,
	input  wire       oscRise,
	// Transfer side
	output reg        busy,
	output wire       commit,
	output reg  [7:0] dataOut
);

	reg [1:0] edges_reg;

	assign commit = busy & oscRise & (edges_reg == `ATP_HOLD_EDGES - 2'h1);

	always @(posedge clk) begin
		if (reset) begin
			busy      <= 1'b0;
			edges_reg <= 2'h0;
			dataOut   <= `ATP_RESET_BYTE;
		end else if (ce) begin
			if (load) begin
				busy      <= 1'b1;
				edges_reg <= 2'h0;
				dataOut   <= dataIn;
			end else if (commit) begin
				busy      <= 1'b0;
			end else if (busy & oscRise) begin
				edges_reg <= edges_reg + 2'h1;
			end
		end
	end

endmodule

// ---- logic/atp_timer.v ----
// Eight-bit timer with dual-slope PWM, crystal clocking and prescaler.
// Assumes an Avalon-MM master, a synchronous crystal input and sleep
// status levels from the power manager.
//
// Implementation choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "atp_consts.vh"

module atp_timer (
	// Clock, reset, enable
	input  wire        clk,
	input  wire        reset,
	input  wire        ce,
	// Avalon-MM slave
	input  wire [4:0]  avsAddress,
	input  wire        avsRead,
	input  wire        avsWrite,
	input  wire [31:0] avsWritedata,
	input  wire [3:0]  avsByteenable,
	output reg  [31:0] avsReaddata,
	output reg         avsWaitrequest,
	// Crystal and sleep
	input  wire        oscInPin,
	input  wire        sleepMode,
	input  wire        deepSleep,
	// Pins and events
	output reg         waveformOut,
	output reg         waveformOutEnable,
	output reg         oscPinsDisconnect,
	output reg         oscEnable,
	output reg         wakeRequest,
	output reg         overflowIrq,
	output reg         compareIrq
);

	localparam PIPE_W = 2 * `ATP_FLAG_SYNC_CPU;

	reg  [7:0]        timerControl_reg;
	reg  [7:0]        counterValue_reg;
	reg  [7:0]        compareValue_reg;
	reg  [7:0]        compareBuf_reg;
	reg  [7:0]        counterShadow_reg;
	reg               asyncSelect_reg;
	reg  [1:0]        flag_reg;
	reg  [1:0]        irqEnable_reg;
	reg               countUp_reg;
	reg               oscPrev_reg;
	reg               armed_reg;
	reg               sleepPrev_reg;
	reg               deepPrev_reg;
	reg               wakePending_reg;
	reg  [1:0]        evtWait_reg;
	reg  [PIPE_W-1:0] evtPipe_reg;

	reg  [7:0]        counter_next;
	reg               countUp_next;
	reg               wave_next;
	reg               overflowHit;
	reg               compareHit;
	reg  [31:0]       readMux;

	wire        oscRise;
	wire        srcTick;
	wire        timerTick;
	wire        busAccept;
	wire        wrStrobe;
	wire        wrCtl;
	wire        wrCnt;
	wire        wrCmp;
	wire        wrAsync;
	wire        wrFlags;
	wire        wrIrqEn;
	wire        wrSpecial;
	wire [2:0]  holdLoad;
	wire [2:0]  busyVec;
	wire [2:0]  commitVec;
	wire [23:0] holdData;
	wire [1:0]  waveMode;
	wire [1:0]  compareMode;
	wire        phaseMode;
	wire [7:0]  compareLive;
	wire        matchEnable;
	wire        upLevel;
	wire        regsLost;
	wire [1:0]  evtRaw;
	wire [1:0]  evtMoved;
	wire [1:0]  flagSet;
	wire [1:0]  flagClear;
	wire        wakeCond;

	function hit;
		input [4:0] addr;
		input [4:0] offset;
		begin
			hit = (addr == offset);
		end
	endfunction

	// The crystal input is sampled in clk; a clk four times faster than
	// the crystal guarantees every edge is seen.
	assign oscRise = oscEnable & oscInPin & ~oscPrev_reg;
	assign srcTick = asyncSelect_reg ? oscRise : 1'b1;

	atp_prescaler u_prescaler (
		.clk         (clk),
		.reset       (reset),
		.ce          (ce),
		.clear       (wrSpecial & avsWritedata[`ATP_SFR_PSR_BIT]),
		.srcTick     (srcTick),
		.clockSelect (timerControl_reg[`ATP_CTL_CS_HI:`ATP_CTL_CS_LO]),
		.timerTick   (timerTick)
	);

	// Bus: a write lands at the edge where waitrequest is seen low.
	assign busAccept = (avsRead | avsWrite) & ~avsWaitrequest;
	assign wrStrobe  = avsWrite & ~avsWaitrequest & avsByteenable[0];
	assign wrCtl     = wrStrobe & hit(avsAddress, `ATP_OFF_CONTROL);
	assign wrCnt     = wrStrobe & hit(avsAddress, `ATP_OFF_COUNTER);
	assign wrCmp     = wrStrobe & hit(avsAddress, `ATP_OFF_COMPARE);
	assign wrAsync   = wrStrobe & hit(avsAddress, `ATP_OFF_ASYNC);
	assign wrFlags   = wrStrobe & hit(avsAddress, `ATP_OFF_FLAGS);
	assign wrIrqEn   = wrStrobe & hit(avsAddress, `ATP_OFF_IRQ_EN);
	assign wrSpecial = wrStrobe & hit(avsAddress, `ATP_OFF_SPECIAL);

	// Index order matches the busy bits: control, compare, counter.
	assign holdLoad = {wrCnt, wrCmp, wrCtl} & {3{asyncSelect_reg}};

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : gHold
			atp_async_hold u_hold (
				.clk     (clk),
				.reset   (reset),
				.ce      (ce),
				.load    (holdLoad[g]),
				.dataIn  (avsWritedata[7:0]),
				.oscRise (oscRise),
				.busy    (busyVec[g]),
				.commit  (commitVec[g]),
				.dataOut (holdData[8*g+7:8*g])
			);
		end
	endgenerate

	assign waveMode    = {timerControl_reg[`ATP_CTL_WGM1_BIT],
		timerControl_reg[`ATP_CTL_WGM0_BIT]};
	assign compareMode = timerControl_reg[`ATP_CTL_COM_HI:`ATP_CTL_COM_LO];
	assign phaseMode   = (waveMode == `ATP_MODE_PHASE);
	assign compareLive = phaseMode ? compareBuf_reg : compareValue_reg;
	// A pending counter or compare transfer would give false matches.
	assign matchEnable = ~busyVec[`ATP_ASY_CMP_BUSY] &
		~busyVec[`ATP_ASY_CNT_BUSY];
	assign upLevel     = (compareMode == `ATP_COM_SET);
	assign regsLost    = deepPrev_reg & ~deepSleep & asyncSelect_reg;

	always @* begin
		counter_next = counterValue_reg;
		countUp_next = countUp_reg;
		wave_next    = waveformOut;
		overflowHit  = 1'b0;
		compareHit   = 1'b0;
		if (timerTick) begin
			if (phaseMode) begin
				if (countUp_reg) begin
					if (counterValue_reg == `ATP_MAX) begin
						counter_next = `ATP_MAX - 8'h01;
						countUp_next = 1'b0;
					end else begin
						counter_next = counterValue_reg + 8'h01;
					end
				end else begin
					if (counterValue_reg == `ATP_BOTTOM) begin
						counter_next = `ATP_BOTTOM + 8'h01;
						countUp_next = 1'b1;
					end else begin
						counter_next = counterValue_reg - 8'h01;
					end
				end
				overflowHit = (counter_next == `ATP_BOTTOM);
				compareHit  = matchEnable & (counter_next == compareLive);
				if (compareMode[1]) begin
					if (counter_next == `ATP_MAX) begin
						// Up-count level at MAX keeps the period symmetric
						// even when no match was seen on the way up.
						wave_next = (compareValue_reg == `ATP_MAX) ?
							~upLevel : upLevel;
					end else if (compareHit) begin
						if (counter_next > counterValue_reg) begin
							wave_next = upLevel;
						end else if (compareLive != `ATP_BOTTOM) begin
							wave_next = ~upLevel;
						end
					end
				end
			end else begin
				counter_next = counterValue_reg + 8'h01;
				overflowHit  = (counterValue_reg == `ATP_MAX);
				compareHit   = matchEnable & (counter_next == compareLive);
				if (compareHit) begin
					case (compareMode)
					`ATP_COM_TOGGLE: wave_next = ~waveformOut;
					`ATP_COM_CLEAR:  wave_next = 1'b0;
					`ATP_COM_SET:    wave_next = 1'b1;
					default:         wave_next = waveformOut;
					endcase
				end
			end
		end
	end

	// Counter, direction, compare and control storage.
	always @(posedge clk) begin
		if (reset) begin
			timerControl_reg  <= `ATP_RESET_BYTE;
			counterValue_reg  <= `ATP_RESET_BYTE;
			compareValue_reg  <= `ATP_RESET_BYTE;
			compareBuf_reg    <= `ATP_RESET_BYTE;
			counterShadow_reg <= `ATP_RESET_BYTE;
			countUp_reg       <= 1'b1;
			waveformOut       <= 1'b0;
			waveformOutEnable <= 1'b0;
		end else if (ce) begin
			if (regsLost) begin
				timerControl_reg <= `ATP_RESET_BYTE;
				counterValue_reg <= `ATP_RESET_BYTE;
				compareValue_reg <= `ATP_RESET_BYTE;
				countUp_reg      <= 1'b1;
			end else begin
				if (wrCtl & ~asyncSelect_reg) begin
					timerControl_reg <= avsWritedata[7:0] &
						~(8'h01 << `ATP_CTL_FORCE_BIT);
				end else if (commitVec[`ATP_ASY_CTL_BUSY]) begin
					timerControl_reg <= holdData[7:0] &
						~(8'h01 << `ATP_CTL_FORCE_BIT);
				end
				if (wrCnt & ~asyncSelect_reg) begin
					counterValue_reg <= avsWritedata[7:0];
				end else if (commitVec[`ATP_ASY_CNT_BUSY]) begin
					counterValue_reg <= holdData[23:16];
				end else begin
					counterValue_reg <= counter_next;
				end
				countUp_reg <= countUp_next;
				if (wrCmp & ~asyncSelect_reg) begin
					compareValue_reg <= avsWritedata[7:0];
				end else if (commitVec[`ATP_ASY_CMP_BUSY]) begin
					compareValue_reg <= holdData[15:8];
				end
			end
			// The dual-slope compare value only changes at MAX.
			if (~phaseMode | (timerTick & (counter_next == `ATP_MAX))) begin
				compareBuf_reg <= compareValue_reg;
			end
			// Updated per timer tick only, never resynchronised to clk.
			waveformOut       <= wave_next;
			waveformOutEnable <= (compareMode != `ATP_COM_OFF);
			// The shadow freezes in sleep so a read after waking shows the
			// pre-sleep count until the next crystal edge.
			if (oscRise & ~sleepMode) begin
				counterShadow_reg <= counterValue_reg;
			end
		end
	end

	// Flag events cross one timer cycle, then three clk stages.
	assign evtRaw   = {compareHit, overflowHit};
	assign evtMoved = timerTick ? evtWait_reg : 2'h0;
	assign flagSet  = asyncSelect_reg ?
		evtPipe_reg[PIPE_W-1:PIPE_W-2] : evtRaw;
	assign flagClear = wrFlags ? avsWritedata[1:0] : 2'h0;
	assign wakeCond  = sleepMode & armed_reg & |(evtRaw & irqEnable_reg);

	always @(posedge clk) begin
		if (reset) begin
			asyncSelect_reg   <= 1'b0;
			flag_reg          <= 2'h0;
			irqEnable_reg     <= 2'h0;
			evtWait_reg       <= 2'h0;
			evtPipe_reg       <= {PIPE_W{1'b0}};
			oscPrev_reg       <= 1'b0;
			armed_reg         <= 1'b0;
			sleepPrev_reg     <= 1'b0;
			deepPrev_reg      <= 1'b0;
			wakePending_reg   <= 1'b0;
			wakeRequest       <= 1'b0;
			oscEnable         <= 1'b0;
			oscPinsDisconnect <= 1'b0;
			overflowIrq       <= 1'b0;
			compareIrq        <= 1'b0;
		end else if (ce) begin
			if (wrAsync) begin
				asyncSelect_reg <= avsWritedata[`ATP_ASY_SEL_BIT];
			end
			if (wrIrqEn) begin
				irqEnable_reg <= avsWritedata[1:0];
			end
			evtWait_reg <= (timerTick ? 2'h0 : evtWait_reg) | evtRaw;
			evtPipe_reg <= {evtPipe_reg[PIPE_W-3:0], evtMoved};
			// A set in the clearing cycle wins.
			flag_reg    <= (flag_reg & ~flagClear) | flagSet;
			overflowIrq <= flag_reg[`ATP_FLG_OVF_BIT] &
				irqEnable_reg[`ATP_FLG_OVF_BIT];
			compareIrq  <= flag_reg[`ATP_FLG_CMP_BIT] &
				irqEnable_reg[`ATP_FLG_CMP_BIT];
			oscPrev_reg   <= oscInPin;
			sleepPrev_reg <= sleepMode;
			deepPrev_reg  <= deepSleep;
			// Disarmed on waking until one crystal edge has passed.
			if (oscRise) begin
				armed_reg <= 1'b1;
			end else if (sleepPrev_reg & ~sleepMode) begin
				armed_reg <= 1'b0;
			end
			if (~sleepMode) begin
				wakePending_reg <= 1'b0;
			end else if (wakeCond) begin
				wakePending_reg <= 1'b1;
			end else if (timerTick) begin
				wakePending_reg <= 1'b0;
			end
			wakeRequest <= wakePending_reg & timerTick & sleepMode;
			oscEnable   <= asyncSelect_reg & ~deepSleep;
			oscPinsDisconnect <= asyncSelect_reg;
		end
	end

	always @* begin
		readMux = 32'h00000000;
		case (avsAddress)
		`ATP_OFF_CONTROL: readMux[7:0] = timerControl_reg;
		`ATP_OFF_COUNTER: readMux[7:0] = asyncSelect_reg ?
			counterShadow_reg : counterValue_reg;
		`ATP_OFF_COMPARE: readMux[7:0] = compareValue_reg;
		`ATP_OFF_ASYNC:   readMux[3:0] = {asyncSelect_reg, busyVec};
		`ATP_OFF_FLAGS:   readMux[1:0] = flag_reg;
		`ATP_OFF_IRQ_EN:  readMux[1:0] = irqEnable_reg;
		default:          readMux = 32'h00000000;
		endcase
	end

	// One wait cycle per request; read data is loaded as waitrequest falls.
	always @(posedge clk) begin
		if (reset) begin
			avsWaitrequest <= 1'b1;
			avsReaddata    <= 32'h00000000;
		end else if (ce) begin
			if (busAccept) begin
				avsWaitrequest <= 1'b1;
			end else if (avsRead | avsWrite) begin
				avsWaitrequest <= 1'b0;
				// Writes leave the last read data standing.
				if (avsRead) begin
					avsReaddata <= readMux;
				end
			end
		end
	end

endmodule

// ---- test/atp_timer_chk.sv ----
// Port checker for the dual-slope timer, bound into atp_timer.
// Assumes ce stays high and the crystal is far slower than clk.
`timescale 1ns/1ps
module atp_timer_chk (
	// Clock and reset
	input wire        clk,
	input wire        reset,
	// Bus
	input wire        avsRead,
	input wire        avsWrite,
	input wire [31:0] avsReaddata,
	input wire        avsWaitrequest,
	// Crystal, sleep, pins
	input wire        oscInPin,
	input wire        sleepMode,
	input wire        deepSleep,
	input wire        waveformOut,
	input wire        waveformOutEnable,
	input wire        oscPinsDisconnect,
	input wire        oscEnable,
	input wire        wakeRequest,
	input wire        overflowIrq
);
	reg       oscPrev_reg;
	reg [3:0] sinceRise_reg;
	wire      req;
	wire      taken;
	assign req = avsRead | avsWrite;
	assign taken = req & ~avsWaitrequest;
	// Leaving deep sleep drops the registers, so it counts as a timer event.
	always @(posedge clk) begin
		oscPrev_reg <= oscInPin;
		if (reset)
			sinceRise_reg <= 4'hf;
		else if ((oscInPin & ~oscPrev_reg) | deepSleep)
			sinceRise_reg <= 4'h0;
		else if (sinceRise_reg != 4'hf)
			sinceRise_reg <= sinceRise_reg + 4'h1;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	a_wait_cause: assert property (!avsWaitrequest |->
		$past(req) && $past(avsWaitrequest))
		else $error("wait low without a pending request");
	a_req_answered: assert property (req && avsWaitrequest |=>
		!avsWaitrequest) else $error("request not answered");
	a_rd_stable: assert property ($changed(avsReaddata) |->
		$fell(avsWaitrequest) && $past(avsRead))
		else $error("read data moved outside a read");
	a_osc_enable: assert property (
		oscEnable == (oscPinsDisconnect && !$past(deepSleep)))
		else $error("oscillator enable wrong");
	a_wake_pulse: assert property (wakeRequest |->
		$past(sleepMode) && (!oscPinsDisconnect || sinceRise_reg <= 4'hc)
		##1 !wakeRequest) else $error("wake pulse wrong");
	a_wave_async: assert property ($changed(waveformOut) &&
		oscPinsDisconnect && $past(oscPinsDisconnect) |->
		sinceRise_reg <= 4'hc) else $error("output off timer clock");
	a_oe_after_write: assert property ($changed(waveformOutEnable) &&
		!oscPinsDisconnect |-> $past(taken) || $past(taken, 2))
		else $error("output enable moved without a write");
	a_disc_after_write: assert property (
		$changed(oscPinsDisconnect) |-> $past(taken) || $past(taken, 2))
		else $error("pin release moved without a write");
	c_wake: cover property ($rose(wakeRequest));
	c_ovf: cover property ($rose(overflowIrq));
	c_async_wave: cover property ($changed(waveformOut) && oscPinsDisconnect);
endmodule

bind atp_timer atp_timer_chk chk_u (
	.clk(clk), .reset(reset), .avsRead(avsRead), .avsWrite(avsWrite),
	.avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
	.oscInPin(oscInPin), .sleepMode(sleepMode), .deepSleep(deepSleep),
	.waveformOut(waveformOut), .waveformOutEnable(waveformOutEnable),
	.oscPinsDisconnect(oscPinsDisconnect), .oscEnable(oscEnable),
	.wakeRequest(wakeRequest), .overflowIrq(overflowIrq)
);

// ---- test/atp_osc_model.sv ----
// Crystal model driving the timer's oscillator input pin.
// Assumes run follows the timer's oscillator enable output.
`timescale 1ns/1ps
module atp_osc_model #(
	parameter integer HALF_NS = 500
) (
	// Control
	input  wire run,
	// Oscillator pin
	output reg  oscPin
);
	// Ten bus clocks per half period keep the crystal far below a quarter
	// of clk; the offset keeps its edges clear of clk edges.
	initial begin
		oscPin = 1'b0;
		#17;
		forever begin
			#(HALF_NS);
			if (run)
				oscPin = ~oscPin;
		end
	end
endmodule

// ---- test/tb.sv ----
// Self-checking bench for atp_timer over its Avalon-MM slave.
// Assumes the crystal model and the bound port checker.
`timescale 1ns/1ps
`include "atp_consts.vh"
module tb;
	reg         clk;
	reg         reset;
	reg         ce;
	reg  [4:0]  avsAddress;
	reg         avsRead;
	reg         avsWrite;
	reg  [31:0] avsWritedata;
	reg  [3:0]  avsByteenable;
	wire [31:0] avsReaddata;
	wire        avsWaitrequest;
	wire        oscInPin;
	reg         sleepMode;
	reg         deepSleep;
	wire        waveformOut;
	wire        oscPinsDisconnect;
	wire        oscEnable;
	wire        wakeRequest;
	wire        overflowIrq;
	wire        compareIrq;
	integer     err_total;
	integer     tests_run;
	integer     i;
	reg  [31:0] cyc;
	reg  [31:0] rdv;
	reg  [31:0] v;
	reg  [31:0] e;
	reg  [31:0] h;
	reg  [31:0] t;
	reg  [31:0] t2;
	reg  [7:0]  c;

	atp_timer dut_u (.clk(clk), .reset(reset), .ce(ce),
		.avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
		.avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
		.avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
		.oscInPin(oscInPin), .sleepMode(sleepMode), .deepSleep(deepSleep),
		.waveformOut(waveformOut), .waveformOutEnable(),
		.oscPinsDisconnect(oscPinsDisconnect), .oscEnable(oscEnable),
		.wakeRequest(wakeRequest), .overflowIrq(overflowIrq),
		.compareIrq(compareIrq));
	atp_osc_model osc_u (.run(oscEnable), .oscPin(oscInPin));

	task check(input [8*12:1] nm, input [31:0] ex, input [31:0] got);
		begin
			tests_run = tests_run + 1;
			if (got !== ex) begin
				err_total = err_total + 1;
				$display("ERROR %0s expected %h seen %h", nm, ex, got);
			end
		end
	endtask
	// Holds the request until waitrequest is sampled low.
	task bus(input rd, input [4:0] a, input [7:0] d);
		integer n;
		begin
			@(posedge clk);
			avsAddress <= a;
			avsRead <= rd;
			avsWrite <= ~rd;
			avsWritedata <= {24'h000000, d};
			n = 0;
			@(posedge clk);
			while (avsWaitrequest !== 1'b0 && n < 50) begin
				n = n + 1;
				@(posedge clk);
			end
			rdv = {24'h000000, avsReaddata[7:0]};
			avsRead <= 1'b0;
			avsWrite <= 1'b0;
			if (n == 50)
				check("bus_wait", 32'h0, 32'h1);
		end
	endtask
	task wait_hi(input w, output [31:0] at);
		integer n;
		begin
			n = 0;
			while ((w ? wakeRequest : overflowIrq) !== 1'b1 && n < 20000) begin
				n = n + 1;
				@(posedge clk);
			end
			at = cyc;
			if (n == 20000)
				check("wait_hi", 32'h1, 32'h0);
		end
	endtask
	function [31:0] div_of(input [2:0] s);
		case (s)
			3'h2: div_of = 32'h8;
			3'h3: div_of = 32'h20;
			3'h4: div_of = 32'h40;
			3'h5: div_of = 32'h80;
			3'h6: div_of = 32'h100;
			3'h7: div_of = 32'h400;
			default: div_of = 32'h1;
		endcase
	endfunction
	task print_verdict;
		begin
			$display("Checks %0d, mismatches %0d", tests_run, err_total);
			if (err_total == 0 && tests_run > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk)
		cyc <= cyc + 32'h1;
	initial begin
		repeat (100000) @(posedge clk);
		err_total = err_total + 1;
		print_verdict;
	end

	initial begin
		cyc = 32'h0;
		err_total = 0;
		tests_run = 0;
		reset = 1'b1;
		ce = 1'b1;
		avsAddress = 5'h00;
		avsRead = 1'b0;
		avsWrite = 1'b0;
		avsWritedata = 32'h0;
		avsByteenable = 4'h1;
		sleepMode = 1'b0;
		deepSleep = 1'b0;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		for (i = 0; i < 8; i = i + 1) begin
			bus(1'b1, {i[2:0], 2'h0}, 8'h00);
			check("reset_read", 32'h0, rdv);
		end
		bus(1'b0, `ATP_OFF_CONTROL, 8'h80);
		bus(1'b1, `ATP_OFF_CONTROL, 8'h00);
		check("force_bit", 32'h0, rdv);
		$display("Test reset done");
		for (i = 0; i < 8; i = i + 1) begin
			bus(1'b0, `ATP_OFF_CONTROL, {5'h00, i[2:0]});
			t = cyc + 32'h4;
			while (cyc != t) @(posedge clk);
			bus(1'b1, `ATP_OFF_COUNTER, 8'h00);
			v = rdv;
			while (cyc != t + 32'h10 * div_of(i[2:0])) @(posedge clk);
			bus(1'b1, `ATP_OFF_COUNTER, 8'h00);
			e = (i == 0) ? 32'h0 : 32'h10;
			check("tick_count", e, (rdv - v) & 32'hff);
		end
		bus(1'b0, `ATP_OFF_CONTROL, 8'h02);
		for (i = 0; i < 2; i = i + 1) begin
			repeat (i * 5) @(posedge clk);
			bus(1'b0, `ATP_OFF_SPECIAL, 8'h01);
			bus(1'b0, `ATP_OFF_COUNTER, 8'h00);
			repeat (37) @(posedge clk);
			bus(1'b1, `ATP_OFF_COUNTER, 8'h00);
			if (i == 0)
				v = rdv;
		end
		check("psr_phase", v, rdv);
		// Ticks fall every eighth cycle from the reset; five precede the read.
		check("psr_count", 32'h5, rdv);
		$display("Test prescaler done");
		// High time per 510-tick period is twice the compare value with setting 2, the rest of the period with setting 3.
		for (i = 0; i < 6; i = i + 1) begin
			c = (i < 2) ? 8'h00 : (i < 4) ? 8'hff : 8'h40;
			e = (c == 8'hff) ? 32'h1fe : {23'h0, c, 1'b0};
			bus(1'b0, `ATP_OFF_COMPARE, c);
			bus(1'b0, `ATP_OFF_CONTROL, i[0] ? 8'h71 : 8'h61);
			repeat (1100) @(posedge clk);
			h = 32'h0;
			repeat (510) begin
				@(posedge clk);
				if (waveformOut === 1'b1)
					h = h + 32'h1;
			end
			check("pwm_high", i[0] ? 32'h1fe - e : e, h);
		end
		bus(1'b0, `ATP_OFF_FLAGS, 8'h01);
		bus(1'b0, `ATP_OFF_IRQ_EN, 8'h01);
		// The first rise may come from a flag set before the enable landed.
		for (i = 0; i < 3; i = i + 1) begin
			t = t2;
			wait_hi(1'b0, t2);
			bus(1'b0, `ATP_OFF_FLAGS, 8'h01);
			repeat (3) @(posedge clk);
		end
		check("ovf_period", 32'h1fe, t2 - t);
		bus(1'b0, `ATP_OFF_FLAGS, 8'h02);
		bus(1'b0, `ATP_OFF_IRQ_EN, 8'h02);
		repeat (2) @(posedge clk);
		check("cmp_clr", 32'h0, {31'h0, compareIrq});
		repeat (520) @(posedge clk);
		check("cmp_irq", 32'h1, {31'h0, compareIrq});
		$display("Test pwm done");
		bus(1'b0, `ATP_OFF_IRQ_EN, 8'h00);
		bus(1'b0, `ATP_OFF_ASYNC, 8'h08);
		repeat (2) @(posedge clk);
		check("pins_free", 32'h1, {31'h0, oscPinsDisconnect});
		check("osc_run", 32'h1, {31'h0, oscEnable});
		@(posedge oscInPin);
		repeat (3) @(posedge clk);
		bus(1'b0, `ATP_OFF_COUNTER, 8'h20);
		bus(1'b0, `ATP_OFF_COMPARE, 8'h28);
		bus(1'b0, `ATP_OFF_CONTROL, 8'h61);
		bus(1'b1, `ATP_OFF_ASYNC, 8'h00);
		check("busy_set", 32'h0f, rdv);
		@(posedge oscInPin);
		repeat (8) @(posedge clk);
		bus(1'b1, `ATP_OFF_ASYNC, 8'h00);
		check("busy_hold", 32'h0f, rdv);
		@(posedge oscInPin);
		repeat (8) @(posedge clk);
		bus(1'b1, `ATP_OFF_ASYNC, 8'h00);
		check("busy_done", 32'h08, rdv);
		bus(1'b1, `ATP_OFF_COMPARE, 8'h00);
		check("cmp_moved", 32'h28, rdv);
		@(posedge oscInPin);
		repeat (3) @(posedge clk);
		bus(1'b1, `ATP_OFF_COUNTER, 8'h00);
		v = rdv;
		repeat (8) @(posedge oscInPin);
		repeat (3) @(posedge clk);
		bus(1'b1, `ATP_OFF_COUNTER, 8'h00);
		check("async_count", 32'h8, (rdv - v) & 32'hff);
		bus(1'b0, `ATP_OFF_FLAGS, 8'h03);
		bus(1'b0, `ATP_OFF_IRQ_EN, 8'h01);
		sleepMode <= 1'b1;
		wait_hi(1'b1, t);
		sleepMode <= 1'b0;
		// The flag crosses on the waking tick, then three clk stages.
		repeat (4) @(posedge clk);
		check("wake_irq", 32'h1, {31'h0, overflowIrq});
		bus(1'b0, `ATP_OFF_COMPARE, 8'h28);
		rdv = 32'h2;
		while (rdv[1] === 1'b1) bus(1'b1, `ATP_OFF_ASYNC, 8'h00);
		bus(1'b1, `ATP_OFF_COUNTER, 8'h00);
		check("woke_count", 32'h1, {31'h0, rdv != 32'h0});
		deepSleep <= 1'b1;
		repeat (3) @(posedge clk);
		check("osc_stop", 32'h0, {31'h0, oscEnable});
		deepSleep <= 1'b0;
		repeat (3) @(posedge clk);
		bus(1'b1, `ATP_OFF_CONTROL, 8'h00);
		check("ctl_lost", 32'h0, rdv);
		$display("Test async done");
		print_verdict;
	end
endmodule
